// *** sgc_regs.vh ***
// Purpose: Named constants for the coded guard sensor state controller.
// Assumes: A 10 MHz system clock; times are converted to cycles where they are used.
// Notes: Times keep their printed figure; cycle counts derive from them.
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// Clock rate in kHz and MHz, used to turn times into cycle counts.
`define SGC_CLK_KHZ 10000
`define SGC_CLK_MHZ 10

// Response limits, kept as the printed figures.
`define SGC_IN_RESP_MS 15
`define SGC_TAG_RESP_MS 50

// Tag loss filter, chosen below the removal response limit.
`define SGC_TAG_LOSS_MS 40

// Feedback switching window.
`define SGC_FB_WIN_MS 500

// Test pulse limit and the pulse length actually used.
`define SGC_TP_MAX_US 300
`define SGC_TP_US 200

// Test pulse period, self-test period and half blink period.
`define SGC_TP_PERIOD_MS 100
`define SGC_SELFTEST_MS 100
`define SGC_BLINK_HALF_MS 500

// Short fixed counts: boot and settle in cycles, error sequence in blink steps.
`define SGC_BOOT_CYC 8'h10
`define SGC_SETTLE_CYC 8'h08
`define SGC_ERRSEQ_LEN 4'hF

// Counter width wide enough for the longest time.
`define SGC_CW 23

// Operating states.
`define SGC_ST_BOOT 3'h0
`define SGC_ST_IDLE 3'h1
`define SGC_ST_ON 3'h2
`define SGC_ST_LIMIT 3'h3
`define SGC_ST_PROG 3'h4
`define SGC_ST_ERR 3'h5

// Error codes.
`define SGC_ERR_NONE 3'h0
`define SGC_ERR_SUPPLY 3'h1
`define SGC_ERR_SELFTEST 3'h2
`define SGC_ERR_OUTPUT 3'h3
`define SGC_ERR_FEEDBACK 3'h4

// Indicator colours as {red, green, blue}.
`define SGC_LED_OFF 3'h0
`define SGC_LED_RED 3'h4
`define SGC_LED_GREEN 3'h2
`define SGC_LED_YELLOW 3'h6
`define SGC_LED_PURPLE 3'h5

`endif

// *** sgc_sync.v ***
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/10ps
module sgc_sync #(
	parameter W = 1
) (
	input wire sys_clk,
	input wire rstn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// Two stages clear to zero so every pin reads inactive in reset.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule // sgc_sync

// *** sgc_guard_ctrl.v ***
// Overview of operation
// - Any shared-code actuator is accepted as valid.
// - A unique-code actuator is accepted only if it matches the stored association.
// - A new association replaces the old identity, which is then rejected.
// - Association may be repeated without any limit on the count.
// - Green when actuator in safe zone, inputs active and outputs on.
// - Steady yellow in normal operation with no actuator present.
// - Red in error, with a dark-blink sequence that encodes the error.
// - Purple while the new actuator procedure runs.
// - Supply is watched and a periodic self-test loop is checked.
// - Safety inputs and actuator zone are tracked and feed the decision.
// - Outputs are driven and read back to catch shorts and faults.
// - Contactor feedback must follow every output change within its window.
// - Programming input activation starts the replacement procedure.
// - Outputs turn on only with inputs good and actuator in safe zone.
// - At power-up without actuator: outputs off, indicator steady yellow.
// - Entering the safe zone turns outputs on and indicator steady green.
// - Safe to limit zone keeps outputs on and flashes yellow.
// - Leaving the limit zone turns outputs off and steady yellow.
// - Outputs go off within 15 ms of either safety input dropping.
// - Outputs go off within 50 ms of actuator removal.
// - Test pulses on active outputs last under 300 us.
//
// Purpose: State controller of a contactless coded guard sensor.
// Assumes: Tag reader logic on sys_clk supplies presence, class, zone and identity.
// Notes: Pins are synchronised; variant straps are caught after reset release.
`timescale 1ns/10ps
`include "sgc_regs.vh"
module sgc_guard_ctrl #(
	parameter [`SGC_CW-1:0] TAG_LOSS_CYC = `SGC_TAG_LOSS_MS * `SGC_CLK_KHZ,
	parameter [`SGC_CW-1:0] FB_WIN_CYC = `SGC_FB_WIN_MS * `SGC_CLK_KHZ,
	parameter [`SGC_CW-1:0] TP_PERIOD_CYC = `SGC_TP_PERIOD_MS * `SGC_CLK_KHZ,
	parameter [`SGC_CW-1:0] SELFTEST_CYC = `SGC_SELFTEST_MS * `SGC_CLK_KHZ,
	parameter [`SGC_CW-1:0] BLINK_HALF_CYC = `SGC_BLINK_HALF_MS * `SGC_CLK_KHZ
) (
	input wire sys_clk,
	input wire rstn,
	input wire safety_input_a,
	input wire safety_input_b,
	input wire programming_input,
	input wire contactor_feedback_input,
	input wire supply_ok,
	input wire selftest_echo,
	input wire readback_a,
	input wire readback_b,
	input wire strap_safety_inputs,
	input wire strap_feedback,
	input wire strap_programming,
	input wire tag_valid,
	input wire tag_unique,
	input wire [15:0] tag_id,
	input wire tag_in_safe,
	input wire tag_in_limit,
	output reg safety_output_a,
	output reg safety_output_b,
	output reg signalling_output,
	output reg led_red,
	output reg led_green,
	output reg led_blue,
	output reg selftest_probe,
	output reg [2:0] error_code
);
	// Test pulse length, derived from its time and the clock rate.
	localparam [`SGC_CW-1:0] TP_CYC = `SGC_TP_US * `SGC_CLK_MHZ;

	wire [10:0] pin_sync;
	wire supply_s;
	wire echo_s;
	wire in_a_s;
	wire in_b_s;
	wire prog_s;
	wire fb_s;
	wire rb_a_s;
	wire rb_b_s;
	wire strap_si_s;
	wire strap_fb_s;
	wire strap_pg_s;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] err_reg;
	reg [2:0] err_next;
	reg [7:0] boot_cnt_reg;
	reg has_si_reg;
	reg has_fb_reg;
	reg has_pg_reg;
	reg [15:0] assoc_id_reg;
	reg assoc_valid_reg;
	reg learn;
	reg prog_prev_reg;
	reg [`SGC_CW-1:0] loss_cnt_reg;
	reg [`SGC_CW-1:0] tp_cnt_reg;
	reg pulse_reg;
	reg [7:0] settle_cnt_reg;
	reg out_on_prev_reg;
	reg [`SGC_CW-1:0] fb_cnt_reg;
	reg fb_pend_reg;
	reg [`SGC_CW-1:0] st_cnt_reg;
	reg [`SGC_CW-1:0] blink_cnt_reg;
	reg blink_reg;
	reg [3:0] seq_reg;
	reg [2:0] led_next;

	wire inputs_ok;
	wire accepted;
	wire out_on;
	wire drive;
	wire prog_rise;
	wire fault_output;
	wire fault_feedback;
	wire fault_selftest;
	wire tag_lost;
	wire st_tick;
	wire blink_tick;

	// All pins pass two flip-flops before any logic reads them.
	sgc_sync #(
		.W(11)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din({supply_ok, selftest_echo, safety_input_a, safety_input_b,
			programming_input, contactor_feedback_input, readback_a, readback_b,
			strap_safety_inputs, strap_feedback, strap_programming}),
		.dout(pin_sync)
	);

	assign supply_s = pin_sync[10];
	assign echo_s = pin_sync[9];
	assign in_a_s = pin_sync[8];
	assign in_b_s = pin_sync[7];
	assign prog_s = pin_sync[6];
	assign fb_s = pin_sync[5];
	assign rb_a_s = pin_sync[4];
	assign rb_b_s = pin_sync[3];
	assign strap_si_s = pin_sync[2];
	assign strap_fb_s = pin_sync[1];
	assign strap_pg_s = pin_sync[0];

	// Input watch: both safety inputs must be active where they are fitted.
	assign inputs_ok = !has_si_reg || (in_a_s && in_b_s);
	// Shared-code tags always pass; unique tags must match the association.
	assign accepted = tag_valid && (!tag_unique ||
		(assoc_valid_reg && (tag_id == assoc_id_reg)));
	assign out_on = (state_reg == `SGC_ST_ON) || (state_reg == `SGC_ST_LIMIT);
	// Off-going test pulses cut the drive briefly while outputs are on.
	assign drive = out_on && !pulse_reg;
	assign prog_rise = has_pg_reg && prog_s && !prog_prev_reg;
	assign tag_lost = !(accepted && (tag_in_safe || tag_in_limit));
	assign st_tick = (st_cnt_reg == SELFTEST_CYC - 1'b1);
	assign blink_tick = (blink_cnt_reg == BLINK_HALF_CYC - 1'b1);

	// Readback must equal the drive once it has settled; a mismatch is a short.
	assign fault_output = (settle_cnt_reg == `SGC_SETTLE_CYC) &&
		((rb_a_s != safety_output_a) || (rb_b_s != safety_output_b));
	// Feedback is a normally closed contact: it reads the inverse of the outputs.
	assign fault_feedback = has_fb_reg && (fb_s == out_on_prev_reg) &&
		(!fb_pend_reg || (fb_cnt_reg == FB_WIN_CYC - 1'b1));
	// The probe loop must echo the last probe level at each self-test tick.
	assign fault_selftest = st_tick && (echo_s != selftest_probe);

	// Error selection in fixed priority; once latched it never changes.
	always @*
	begin
		err_next = err_reg;
		if (state_reg != `SGC_ST_BOOT && err_reg == `SGC_ERR_NONE)
		begin
			if (!supply_s)
				err_next = `SGC_ERR_SUPPLY;
			else if (fault_selftest)
				err_next = `SGC_ERR_SELFTEST;
			else if (fault_output)
				err_next = `SGC_ERR_OUTPUT;
			else if (fault_feedback)
				err_next = `SGC_ERR_FEEDBACK;
		end
	end

	// Main state decision, with zone hysteresis and the learn procedure.
	always @*
	begin
		state_next = state_reg;
		learn = 1'b0;
		case (state_reg)
			`SGC_ST_BOOT:
			begin
				if (boot_cnt_reg == `SGC_BOOT_CYC)
					state_next = `SGC_ST_IDLE;
			end
			`SGC_ST_IDLE:
			begin
				if (prog_rise)
					state_next = `SGC_ST_PROG;
				else if (!has_pg_reg && !assoc_valid_reg && tag_valid && tag_unique &&
					tag_in_safe)
					learn = 1'b1;
				else if (accepted && tag_in_safe && inputs_ok)
					state_next = `SGC_ST_ON;
			end
			`SGC_ST_ON:
			begin
				if (!inputs_ok)
					state_next = `SGC_ST_IDLE;
				else if (tag_lost && loss_cnt_reg == TAG_LOSS_CYC - 1'b1)
					state_next = `SGC_ST_IDLE;
				else if (accepted && !tag_in_safe && tag_in_limit)
					state_next = `SGC_ST_LIMIT;
			end
			`SGC_ST_LIMIT:
			begin
				if (!inputs_ok)
					state_next = `SGC_ST_IDLE;
				else if (tag_lost && loss_cnt_reg == TAG_LOSS_CYC - 1'b1)
					state_next = `SGC_ST_IDLE;
				else if (accepted && tag_in_safe)
					state_next = `SGC_ST_ON;
			end
			`SGC_ST_PROG:
			begin
				if (tag_valid && tag_unique && tag_in_safe)
				begin
					learn = 1'b1;
					state_next = `SGC_ST_IDLE;
				end
			end
			`SGC_ST_ERR:
				state_next = `SGC_ST_ERR;
			default:
				state_next = `SGC_ST_ERR;
		endcase
		if (err_next != `SGC_ERR_NONE)
			state_next = `SGC_ST_ERR;
	end

	// State, error latch, boot delay and variant straps caught after release.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= `SGC_ST_BOOT;
			err_reg <= `SGC_ERR_NONE;
			boot_cnt_reg <= 8'h00;
			has_si_reg <= 1'b0;
			has_fb_reg <= 1'b0;
			has_pg_reg <= 1'b0;
			prog_prev_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			err_reg <= err_next;
			prog_prev_reg <= prog_s;
			if (state_reg == `SGC_ST_BOOT)
			begin
				boot_cnt_reg <= boot_cnt_reg + 8'h01;
				has_si_reg <= strap_si_s;
				has_fb_reg <= strap_fb_s;
				has_pg_reg <= strap_pg_s;
			end
		end
	end

	// Association store: a new identity overwrites the old one outright.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			assoc_id_reg <= 16'h0000;
			assoc_valid_reg <= 1'b0;
		end
		else if (learn && err_next == `SGC_ERR_NONE)
		begin
			assoc_id_reg <= tag_id;
			assoc_valid_reg <= 1'b1;
		end
	end

	// Tag loss filter, restarted whenever an accepted tag is seen in range.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			loss_cnt_reg <= {`SGC_CW{1'b0}};
		else if (!out_on || !tag_lost)
			loss_cnt_reg <= {`SGC_CW{1'b0}};
		else if (loss_cnt_reg != TAG_LOSS_CYC - 1'b1)
			loss_cnt_reg <= loss_cnt_reg + 1'b1;
	end

	// Test pulse timer: one short low pulse per period while outputs are on.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tp_cnt_reg <= {`SGC_CW{1'b0}};
			pulse_reg <= 1'b0;
		end
		else if (!out_on)
		begin
			tp_cnt_reg <= {`SGC_CW{1'b0}};
			pulse_reg <= 1'b0;
		end
		else if (pulse_reg)
		begin
			if (tp_cnt_reg == TP_CYC - 1'b1)
			begin
				pulse_reg <= 1'b0;
				tp_cnt_reg <= {`SGC_CW{1'b0}};
			end
			else
				tp_cnt_reg <= tp_cnt_reg + 1'b1;
		end
		else if (tp_cnt_reg == TP_PERIOD_CYC - 1'b1)
		begin
			pulse_reg <= 1'b1;
			tp_cnt_reg <= {`SGC_CW{1'b0}};
		end
		else
			tp_cnt_reg <= tp_cnt_reg + 1'b1;
	end

	// Output stage; the settle count restarts whenever the drive changes.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			signalling_output <= 1'b0;
			settle_cnt_reg <= 8'h00;
		end
		else
		begin
			safety_output_a <= drive && state_next != `SGC_ST_ERR;
			safety_output_b <= drive && state_next != `SGC_ST_ERR;
			signalling_output <= out_on && state_next != `SGC_ST_ERR;
			if (drive != safety_output_a)
				settle_cnt_reg <= 8'h00;
			else if (settle_cnt_reg != `SGC_SETTLE_CYC)
				settle_cnt_reg <= settle_cnt_reg + 8'h01;
		end
	end

	// Feedback window opens at each change of the output state.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_on_prev_reg <= 1'b0;
			fb_pend_reg <= 1'b0;
			fb_cnt_reg <= {`SGC_CW{1'b0}};
		end
		else
		begin
			out_on_prev_reg <= out_on;
			if (out_on != out_on_prev_reg)
			begin
				fb_pend_reg <= 1'b1;
				fb_cnt_reg <= {`SGC_CW{1'b0}};
			end
			else if (fb_pend_reg)
			begin
				if (fb_cnt_reg == FB_WIN_CYC - 1'b1)
					fb_pend_reg <= 1'b0;
				else
					fb_cnt_reg <= fb_cnt_reg + 1'b1;
			end
		end
	end

	// Self-test loop: the probe toggles each period and must be echoed back.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_cnt_reg <= {`SGC_CW{1'b0}};
			selftest_probe <= 1'b0;
		end
		else if (st_tick)
		begin
			st_cnt_reg <= {`SGC_CW{1'b0}};
			selftest_probe <= !selftest_probe;
		end
		else
			st_cnt_reg <= st_cnt_reg + 1'b1;
	end

	// Half-second blink base and the error sequence step counter.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blink_cnt_reg <= {`SGC_CW{1'b0}};
			blink_reg <= 1'b0;
			seq_reg <= 4'h0;
		end
		else if (blink_tick)
		begin
			blink_cnt_reg <= {`SGC_CW{1'b0}};
			blink_reg <= !blink_reg;
			seq_reg <= (seq_reg == `SGC_ERRSEQ_LEN) ? 4'h0 : seq_reg + 4'h1;
		end
		else
			blink_cnt_reg <= blink_cnt_reg + 1'b1;
	end

	// Indicator colour follows the settled state, so green never leads the outputs.
	// An error that latches on this edge takes the indicator at once.
	always @*
	begin
		case ((err_next != `SGC_ERR_NONE) ? `SGC_ST_ERR : state_reg)
			`SGC_ST_ON:
				led_next = `SGC_LED_GREEN;
			`SGC_ST_LIMIT:
				led_next = blink_reg ? `SGC_LED_OFF : `SGC_LED_YELLOW;
			`SGC_ST_PROG:
				led_next = `SGC_LED_PURPLE;
			`SGC_ST_ERR:
			begin
				// Dark blinks, as many as the error code, then steady red.
				if (seq_reg[0] && ({1'b0, seq_reg[3:1]} < {1'b0, err_next}))
					led_next = `SGC_LED_OFF;
				else
					led_next = `SGC_LED_RED;
			end
			`SGC_ST_IDLE:
				led_next = `SGC_LED_YELLOW;
			default:
				led_next = `SGC_LED_YELLOW;
		endcase
	end

	// Indicator and error code registers.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			led_red <= 1'b0;
			led_green <= 1'b0;
			led_blue <= 1'b0;
			error_code <= `SGC_ERR_NONE;
		end
		else
		begin
			led_red <= led_next[2];
			led_green <= led_next[1];
			led_blue <= led_next[0];
			error_code <= err_next;
		end
	end
endmodule // sgc_guard_ctrl

// *** sgc_guard_chk.sv ***
// Purpose: Concurrent checks on the ports of the guard sensor controller.
// Assumes: Bound to every instance of the controller; one clock domain.
// Notes: Small counters stand in for long repetitions.
`timescale 1ns/10ps
`include "sgc_regs.vh"
module sgc_guard_chk #(
	parameter [`SGC_CW-1:0] TAG_LOSS_CYC = 23'h0014
) (
	input wire sys_clk,
	input wire rstn,
	input wire safety_input_a,
	input wire safety_input_b,
	input wire readback_a,
	input wire strap_safety_inputs,
	input wire tag_valid,
	input wire tag_in_safe,
	input wire safety_output_a,
	input wire safety_output_b,
	input wire signalling_output,
	input wire led_red,
	input wire led_green,
	input wire led_blue,
	input wire [2:0] error_code
);
	localparam int TP_MAX_CYC = `SGC_TP_MAX_US * `SGC_CLK_MHZ;
	int gone_cnt;
	int low_cnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Counts cycles without a tag and cycles of an output pulse while active.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gone_cnt <= 0;
			low_cnt <= 0;
		end
		else
		begin
			gone_cnt <= tag_valid ? 0 : gone_cnt + 1;
			low_cnt <= (!safety_output_a && signalling_output) ? low_cnt + 1 : 0;
		end
	end
	// Eight cycles of an active output that is not seen on its sense line.
	sequence s_rb_bad;
		(safety_output_a && !readback_a) [*8];
	endsequence
	a_pair_equal: assert property (safety_output_a == safety_output_b)
		else $error("safety outputs differ");
	a_on_cause: assert property ($rose(safety_output_a) && !$past(signalling_output)
		|-> $past(tag_valid, 2) && $past(tag_in_safe, 2)) else $error("output on without tag");
	a_input_drop: assert property ((strap_safety_inputs && !(safety_input_a && safety_input_b))
		[*6] |-> !safety_output_a) else $error("output stays on after input drop");
	a_tag_gone: assert property (gone_cnt >= TAG_LOSS_CYC + 4 |-> !safety_output_a)
		else $error("output stays on after tag loss");
	a_pulse_short: assert property (low_cnt < TP_MAX_CYC)
		else $error("output test pulse too long");
	a_err_off: assert property (error_code != 3'h0 |-> !safety_output_a && !signalling_output)
		else $error("outputs on in error");
	a_err_hold: assert property (error_code != 3'h0 |=> error_code == $past(error_code))
		else $error("error code not held");
	a_err_colour: assert property (error_code != 3'h0 |-> !led_green && !led_blue)
		else $error("error colour wrong");
	a_green_on: assert property (led_green && !led_red |-> signalling_output)
		else $error("green without active state");
	a_purple_off: assert property (led_red && led_blue |-> !safety_output_a)
		else $error("outputs on while learning");
	a_rb_fault: assert property (s_rb_bad ##1 s_rb_bad |-> error_code != 3'h0)
		else $error("output fault not caught");
endmodule // sgc_guard_chk

bind sgc_guard_ctrl sgc_guard_chk #(.TAG_LOSS_CYC(TAG_LOSS_CYC)) sgc_guard_chk_inst (
	.sys_clk(sys_clk), .rstn(rstn), .safety_input_a(safety_input_a),
	.safety_input_b(safety_input_b), .readback_a(readback_a),
	.strap_safety_inputs(strap_safety_inputs), .tag_valid(tag_valid),
	.tag_in_safe(tag_in_safe), .safety_output_a(safety_output_a),
	.safety_output_b(safety_output_b), .signalling_output(signalling_output),
	.led_red(led_red), .led_green(led_green), .led_blue(led_blue), .error_code(error_code));

// *** sgc_ossd_partner.sv ***
// Purpose: Far side model: OSSD receiver with contactor, output sense and test loop.
// Assumes: Fault modes are commanded only by the bench.
// Notes: The contactor contact is normally closed and lags by fb_dly cycles.
`timescale 1ns/10ps
module sgc_ossd_partner (
	input wire sys_clk,
	input wire rstn,
	input wire safety_output_a,
	input wire safety_output_b,
	input wire selftest_probe,
	input wire [1:0] fault_mode,
	input wire [7:0] fb_dly,
	output wire readback_a,
	output wire readback_b,
	output wire contactor_feedback_input,
	output wire selftest_echo
);
	logic [7:0] lag_reg;
	logic fb_reg;
	wire coil = safety_output_a & safety_output_b;
	// The contact follows the coil once the coil has held for fb_dly cycles.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lag_reg <= 8'h00;
			fb_reg <= 1'b1;
		end
		else if (fb_reg == coil)
		begin
			lag_reg <= lag_reg + 8'h01;
			if (lag_reg >= fb_dly)
			begin
				fb_reg <= !coil;
				lag_reg <= 8'h00;
			end
		end
		else
			lag_reg <= 8'h00;
	end
	// Sense line a, the feedback and the test loop, each breakable by the bench; sense line b is not.
	assign readback_a = (fault_mode == 2'h1) ? 1'b0 : safety_output_a;
	assign readback_b = safety_output_b;
	assign contactor_feedback_input = (fault_mode == 2'h2) ? 1'b1 : fb_reg;
	assign selftest_echo = (fault_mode == 2'h3) ? !selftest_probe : selftest_probe;
endmodule // sgc_ossd_partner

// *** sgc_guard_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the guard sensor controller.
// Assumes: Short counts set by parameter; the bench plays the tag reader.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`include "sgc_regs.vh"
module sgc_guard_ctrl_tb_top;
	localparam [`SGC_CW-1:0] TL = 23'h0014;
	logic sys_clk, rstn, safety_input_a, safety_input_b, programming_input, supply_ok;
	logic strap_safety_inputs, strap_feedback, strap_programming;
	logic tag_valid, tag_unique, tag_in_safe, tag_in_limit;
	logic [15:0] tag_id;
	logic [1:0] fault_mode;
	logic [7:0] fb_dly;
	wire contactor_feedback_input, selftest_echo, readback_a, readback_b, selftest_probe;
	wire safety_output_a, safety_output_b, signalling_output, led_red, led_green, led_blue;
	wire [2:0] error_code;
	wire [2:0] led = {led_red, led_green, led_blue};
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;

	sgc_guard_ctrl #(.TAG_LOSS_CYC(TL), .FB_WIN_CYC(23'h0028), .TP_PERIOD_CYC(23'h0bb8),
		.SELFTEST_CYC(23'h0032), .BLINK_HALF_CYC(23'h000a)) sgc_guard_ctrl_inst (
		.sys_clk(sys_clk), .rstn(rstn), .safety_input_a(safety_input_a),
		.safety_input_b(safety_input_b), .programming_input(programming_input),
		.contactor_feedback_input(contactor_feedback_input), .supply_ok(supply_ok),
		.selftest_echo(selftest_echo), .readback_a(readback_a), .readback_b(readback_b),
		.strap_safety_inputs(strap_safety_inputs), .strap_feedback(strap_feedback),
		.strap_programming(strap_programming), .tag_valid(tag_valid), .tag_unique(tag_unique),
		.tag_id(tag_id), .tag_in_safe(tag_in_safe), .tag_in_limit(tag_in_limit),
		.safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
		.signalling_output(signalling_output), .led_red(led_red), .led_green(led_green),
		.led_blue(led_blue), .selftest_probe(selftest_probe), .error_code(error_code));

	sgc_ossd_partner sgc_ossd_partner_inst (.sys_clk(sys_clk), .rstn(rstn),
		.safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
		.selftest_probe(selftest_probe), .fault_mode(fault_mode), .fb_dly(fb_dly),
		.readback_a(readback_a), .readback_b(readback_b),
		.contactor_feedback_input(contactor_feedback_input), .selftest_echo(selftest_echo));

	// Free running 100 ns clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task wait_out(input logic v, output int n);
		n = 0;
		while (safety_output_a !== v && n < 3200)
		begin
			tick(1);
			n++;
		end
	endtask

	task tag_on(input logic u, input logic [15:0] id);
		tag_valid = 1'b1;
		tag_unique = u;
		tag_id = id;
		tag_in_safe = 1'b1;
		tag_in_limit = 1'b0;
	endtask

	task do_reset(input logic fb, input logic pg);
		rstn = 1'b0;
		{safety_input_a, safety_input_b, supply_ok, strap_safety_inputs} = 4'hf;
		{programming_input, tag_valid, tag_unique, tag_in_safe, tag_in_limit} = 5'h00;
		strap_programming = pg;
		strap_feedback = fb;
		tag_id = 16'h0000;
		fault_mode = 2'h0;
		fb_dly = 8'h05;
		tick(6);
		rstn = 1'b1;
		tick(30);
	endtask

	task t_power;
		chk(safety_output_a, 1'b0);
		chk(led, `SGC_LED_YELLOW);
		$display("TEST power_up done");
	endtask

	task t_zones;
		int n, ny, nd, no;
		tag_on(1'b0, 16'h0000);
		wait_out(1'b1, n);
		chk(n <= 3, 1'b1);
		chk({safety_output_b, signalling_output, led}, {2'h3, `SGC_LED_GREEN});
		wait_out(1'b0, n);
		chk(signalling_output, 1'b1);
		wait_out(1'b1, n);
		chk(n > 1000 && n < 3000, 1'b1);
		tag_in_safe = 1'b0;
		tag_in_limit = 1'b1;
		tick(3);
		ny = 0;
		nd = 0;
		no = 0;
		repeat (24)
		begin
			tick(1);
			ny += (led === `SGC_LED_YELLOW);
			nd += (led === `SGC_LED_OFF);
			no += (safety_output_a === 1'b1);
		end
		chk(no, 24);
		chk(ny >= 10 && ny <= 14 && nd >= 10 && nd <= 14, 1'b1);
		tag_valid = 1'b0;
		wait_out(1'b0, n);
		chk(n <= TL + 4, 1'b1);
		tick(2);
		chk(led, `SGC_LED_YELLOW);
		$display("TEST zones done");
	endtask

	task t_inputs;
		int n, k;
		for (k = 0; k < 2; k++)
		begin
			tag_on(1'b0, 16'h0000);
			wait_out(1'b1, n);
			if (k == 0)
				safety_input_a = 1'b0;
			else
				safety_input_b = 1'b0;
			wait_out(1'b0, n);
			chk(n <= 4 && safety_output_b === 1'b0, 1'b1);
			tick(10);
			chk(safety_output_a, 1'b0);
			{safety_input_a, safety_input_b, tag_valid} = 3'h6;
			tick(TL + 8);
		end
		$display("TEST inputs done");
	endtask

	task t_unique;
		int n, k;
		logic [15:0] ids [2];
		ids = '{16'h1234, 16'hbeef};
		tag_on(1'b1, ids[1]);
		tick(20);
		chk(safety_output_a, 1'b0);
		tag_valid = 1'b0;
		for (k = 0; k < 2; k++)
		begin
			programming_input = 1'b1;
			n = 0;
			while (led !== `SGC_LED_PURPLE && n < 10)
			begin
				tick(1);
				n++;
			end
			chk(led, `SGC_LED_PURPLE);
			programming_input = 1'b0;
			tag_on(1'b1, ids[k]);
			tick(10);
			tag_valid = 1'b0;
			tick(TL + 4);
			chk(safety_output_a, 1'b0);
			tag_on(1'b1, ids[k]);
			wait_out(1'b1, n);
			chk(n <= 3, 1'b1);
			tag_valid = 1'b0;
			wait_out(1'b0, n);
			tag_on(1'b1, ids[1 - k]);
			tick(20);
			chk(safety_output_a, 1'b0);
			tag_valid = 1'b0;
			tick(4);
		end
		$display("TEST unique done");
	endtask

	// Variant without a programming input: the first unique tag is learned on its own.
	task t_auto;
		int n;
		do_reset(1'b0, 1'b0);
		tag_on(1'b1, 16'h5a5a);
		wait_out(1'b1, n);
		chk(n <= 3, 1'b1);
		tag_id = 16'ha5a5;
		wait_out(1'b0, n);
		chk(n <= TL + 4, 1'b1);
		tick(20);
		chk(safety_output_a, 1'b0);
		tag_valid = 1'b0;
		programming_input = 1'b1;
		tick(8);
		chk(led, `SGC_LED_YELLOW);
		programming_input = 1'b0;
		tick(4);
		$display("TEST auto done");
	endtask

	task t_fault;
		int n, k;
		logic [2:0] want [4];
		want = '{`SGC_ERR_SUPPLY, `SGC_ERR_OUTPUT, `SGC_ERR_FEEDBACK, `SGC_ERR_SELFTEST};
		for (k = 0; k < 4; k++)
		begin
			do_reset(k == 2, 1'b1);
			fb_dly = 8'h1e;
			tag_on(1'b0, 16'h0000);
			wait_out(1'b1, n);
			tick(60);
			chk({safety_output_a, error_code}, 4'h8);
			if (k == 0)
				supply_ok = 1'b0;
			else
				fault_mode = k[1:0];
			n = 0;
			while (error_code === 3'h0 && n < 200)
			begin
				tick(1);
				n++;
			end
			chk(error_code, want[k]);
			chk({safety_output_a, safety_output_b, led_green}, 3'h0);
			supply_ok = 1'b1;
			fault_mode = 2'h0;
			tick(20);
			chk(error_code, want[k]);
		end
		$display("TEST faults done");
	endtask

	task test_done;
		$display("COUNT checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			test_done;
		end
	end

	// Main sequence.
	initial
	begin
		do_reset(1'b0, 1'b1);
		t_power;
		t_zones;
		t_inputs;
		t_unique;
		t_auto;
		t_fault;
		test_done;
	end
endmodule // sgc_guard_ctrl_tb_top
